// File: src/tone_gen_defines.svh
`ifndef TONE_GEN_DEFINES_SVH
`define TONE_GEN_DEFINES_SVH
// Destination codes, in write order
`define DEST_T1_FREQ     3'h0
`define DEST_T1_ATT      3'h1
`define DEST_T2_FREQ     3'h2
`define DEST_T2_ATT      3'h3
`define DEST_T3_FREQ     3'h4
`define DEST_T3_ATT      3'h5
`define DEST_NOISE_CTL   3'h6
`define DEST_NOISE_ATT   3'h7
// Load latency in input clocks per variant
`define LOAD_CYC_SLOW    6'h04
`define LOAD_CYC_FAST    6'h20
// Attenuation code that silences a channel
`define ATT_OFF          4'hF
`define ATT_RESET        4'hF
// Noise shift register width and seed
`define LFSR_SEED        16'h8000
`endif

// File: src/tone_gen_pkg.sv
`default_nettype none
// ==========================================
// Shared types
package tone_gen_pkg;
  // Loader state, one-hot
  typedef enum logic [2:0] {
    LD_IDLE = 3'b001,
    LD_BUSY = 3'b010,
    LD_DONE = 3'b100
  } load_state_t;
  // Host write state, one-hot
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_WAIT = 3'b010,
    WR_END  = 3'b100
  } wr_state_t;
endpackage : tone_gen_pkg
`default_nettype wire

// File: src/tone_bus_if.sv
`default_nettype none
// ==========================================
// Write bus between processor and tone generator
interface tone_bus_if;
  logic       chip_sel_n;  // Active-low chip select
  logic       write_n;     // Active-low write strobe
  logic [7:0] data;        // Index is line number; line 0 carries the MSB
  logic       ready;       // High once byte taken
  modport dev  (input chip_sel_n, input write_n, input data, output ready);
  modport host (output chip_sel_n, output write_n, output data, input ready);
endinterface : tone_bus_if
`default_nettype wire

// File: src/tone_gen_dev.sv
`include "tone_gen_defines.svh"
`default_nettype none
module tone_gen_dev #(
  parameter bit FAST_VARIANT = 1'b1  // 1: fast clock, 32-cycle load
) (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // Processor bus
  tone_bus_if.dev         bus,
  // Channel outputs: tone 1..3 in bits 0..2, noise in bit 3
  output logic [3:0]      wave_out,
  output logic [15:0]     level_cut_bits_out
);
  // ==========================================
  // Constants
  localparam logic [5:0] LOAD_CYC = FAST_VARIANT ? `LOAD_CYC_FAST : `LOAD_CYC_SLOW;

  // ==========================================
  // Bus synchronisers
  logic [1:0] cs_sync_q;   // Chip select, active low
  logic [1:0] we_sync_q;   // Write strobe, active low
  logic [7:0] data_q;      // Captured byte, reversed from bus order so bit 7 = MSB
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cs_sync_q <= 2'h3;
      we_sync_q <= 2'h3;
    end else begin
      cs_sync_q <= {cs_sync_q[0], bus.chip_sel_n};
      we_sync_q <= {we_sync_q[0], bus.write_n};
    end
  end
  wire cs_active_w = ~cs_sync_q[1];
  wire start_w     = cs_active_w & ~we_sync_q[1];

  // Reverse lines so index 7 holds line 0 (the MSB)
  function automatic logic [7:0] bus_order(input logic [7:0] d);
    for (int i = 0; i < 8; i++) bus_order[i] = d[7 - i];
  endfunction : bus_order

  // ==========================================
  // Loader state machine
  tone_gen_pkg::load_state_t st_q;
  logic [5:0] cnt_q;       // Load latency counter
  logic       ready_q;     // READY pin
  logic       commit_q;    // One-cycle strobe: write data_q
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q     <= tone_gen_pkg::LD_IDLE;
      cnt_q    <= 6'h00;
      ready_q  <= 1'b1;
      commit_q <= 1'b0;
      data_q   <= 8'h00;
    end else begin
      commit_q <= 1'b0;
      unique case (st_q)
        tone_gen_pkg::LD_IDLE: begin
          // Select alone already drops READY, so the host stalls early
          if (cs_active_w) ready_q <= 1'b0;
          else ready_q <= 1'b1;
          if (start_w) begin
            data_q <= bus_order(bus.data);
            cnt_q  <= LOAD_CYC - 6'h01;
            st_q   <= tone_gen_pkg::LD_BUSY;
          end
        end
        tone_gen_pkg::LD_BUSY: begin
          if (cnt_q == 6'h00) begin
            commit_q <= 1'b1;
            ready_q  <= 1'b1;
            st_q     <= tone_gen_pkg::LD_DONE;
          end else begin
            cnt_q <= cnt_q - 6'h01;
          end
        end
        tone_gen_pkg::LD_DONE: begin
          // Wait for the strobe to go away so one write loads once
          if (we_sync_q[1] | ~cs_active_w) st_q <= tone_gen_pkg::LD_IDLE;
        end
        default: st_q <= tone_gen_pkg::LD_IDLE;
      endcase
    end
  end
  assign bus.ready = ready_q;

  // ==========================================
  // Register file
  logic [2:0] dest_q;          // Latched destination_select
  logic [9:0] period_q [3];    // Half-period per tone
  logic [3:0] att_q    [4];    // Attenuation per channel
  logic [2:0] noise_ctl_q;     // {feedback, rate[1:0]}
  logic       noise_clr_q;     // Pulse: noise control written
  wire        first_w  = data_q[7];                 // Format bit
  wire [2:0]  dsel_w   = first_w ? data_q[6:4] : dest_q;
  wire [1:0]  chan_w   = dsel_w[2:1];
  wire        is_att_w = dsel_w[0];
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      dest_q      <= `DEST_T1_FREQ;
      noise_ctl_q <= 3'h0;
      noise_clr_q <= 1'b0;
      for (int i = 0; i < 3; i++) period_q[i] <= 10'h000;
      for (int i = 0; i < 4; i++) att_q[i] <= `ATT_RESET;
    end else begin
      noise_clr_q <= 1'b0;
      if (commit_q) begin
        if (first_w) dest_q <= data_q[6:4];
        if (is_att_w) begin
          att_q[chan_w] <= data_q[3:0];
        end else if (dsel_w == `DEST_NOISE_CTL) begin
          noise_ctl_q <= data_q[2:0];
          noise_clr_q <= 1'b1;
        end else if (first_w) begin
          // First byte carries the four low-order bits (F6..F9)
          period_q[chan_w][3:0] <= data_q[3:0];
        end else begin
          // Second byte carries the six high-order bits (F0..F5)
          period_q[chan_w][9:4] <= data_q[5:0];
        end
      end
    end
  end

  // ==========================================
  // Tone channels: half-rate down counters
  logic       half_q;           // Divide-by-two enable
  logic [9:0] tcnt_q [3];
  logic [2:0] tone_q;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      half_q <= 1'b0;
      tone_q <= 3'h0;
      for (int i = 0; i < 3; i++) tcnt_q[i] <= 10'h000;
    end else begin
      half_q <= ~half_q;
      if (half_q) begin
        for (int i = 0; i < 3; i++) begin
          // Borrow on the step from one to zero, so a value n lasts n steps
          if (tcnt_q[i] <= 10'h001) begin
            tcnt_q[i] <= period_q[i];
            tone_q[i] <= ~tone_q[i];
          end else begin
            tcnt_q[i] <= tcnt_q[i] - 10'h001;
          end
        end
      end
    end
  end

  // ==========================================
  // Noise channel: LFSR clocked from a fixed divider or tone 3
  logic [7:0]  ndiv_q;         // Free divider for shift rates
  logic        t3_prev_q;      // Tone 3 edge detect
  logic [15:0] lfsr_q;
  wire nstep_w = (noise_ctl_q[1:0] == 2'h0) ? (ndiv_q[5:0] == 6'h3F) :
                 (noise_ctl_q[1:0] == 2'h1) ? (ndiv_q[6:0] == 7'h7F) :
                 (noise_ctl_q[1:0] == 2'h2) ? (ndiv_q == 8'hFF) :
                 (tone_q[2] & ~t3_prev_q);
  // Zero-lock guard: an empty register is refilled with the seed
  wire nfb_w = noise_ctl_q[2] ? (lfsr_q[0] ^ lfsr_q[1]) : lfsr_q[0];
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ndiv_q    <= 8'h00;
      t3_prev_q <= 1'b0;
      lfsr_q    <= `LFSR_SEED;
    end else begin
      ndiv_q    <= ndiv_q + 8'h01;
      t3_prev_q <= tone_q[2];
      if (noise_clr_q | (lfsr_q == 16'h0000)) lfsr_q <= `LFSR_SEED;
      else if (nstep_w) lfsr_q <= {nfb_w, lfsr_q[15:1]};
    end
  end

  // ==========================================
  // Output registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wave_out           <= 4'h0;
      level_cut_bits_out <= {4{`ATT_OFF}};
    end else begin
      wave_out           <= {lfsr_q[0], tone_q};
      level_cut_bits_out <= {att_q[3], att_q[2], att_q[1], att_q[0]};
    end
  end
endmodule : tone_gen_dev
`default_nettype wire

// File: src/tone_gen_host.sv
`include "tone_gen_defines.svh"
`default_nettype none
module tone_gen_host (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // User request
  input  wire logic       wr_req_in,   // Pulse: write wr_data_in
  input  wire logic [7:0] wr_data_in,  // Byte, bit 7 = MSB
  output logic            busy_out,
  output logic            done_out,    // Pulse: byte accepted
  // Bus side
  tone_bus_if.host        bus
);
  // ==========================================
  // Write sequencer
  tone_gen_pkg::wr_state_t st_q;
  logic       cs_n_q;
  logic       we_n_q;
  logic [7:0] data_q;
  logic       rdy_seen_low_q;   // READY must fall before we trust a high
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q           <= tone_gen_pkg::WR_IDLE;
      cs_n_q         <= 1'b1;
      we_n_q         <= 1'b1;
      data_q         <= 8'h00;
      busy_out       <= 1'b0;
      done_out       <= 1'b0;
      rdy_seen_low_q <= 1'b0;
    end else begin
      done_out <= 1'b0;
      unique case (st_q)
        tone_gen_pkg::WR_IDLE: begin
          if (wr_req_in) begin
            // Select and strobe together: zero setup allowed
            cs_n_q   <= 1'b0;
            we_n_q   <= 1'b0;
            data_q   <= wr_data_in;
            busy_out <= 1'b1;
            rdy_seen_low_q <= 1'b0;
            st_q     <= tone_gen_pkg::WR_WAIT;
          end
        end
        tone_gen_pkg::WR_WAIT: begin
          // Wait state; data held until READY returns high
          if (!bus.ready) rdy_seen_low_q <= 1'b1;
          else if (rdy_seen_low_q) begin
            cs_n_q <= 1'b1;
            we_n_q <= 1'b1;
            st_q   <= tone_gen_pkg::WR_END;
          end
        end
        tone_gen_pkg::WR_END: begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          st_q     <= tone_gen_pkg::WR_IDLE;
        end
        default: st_q <= tone_gen_pkg::WR_IDLE;
      endcase
    end
  end
  // Line 0 carries the MSB, so the vector is reversed on the bus
  assign bus.chip_sel_n = cs_n_q;
  assign bus.write_n    = we_n_q;
  assign bus.data       = {data_q[0], data_q[1], data_q[2], data_q[3],
                           data_q[4], data_q[5], data_q[6], data_q[7]};
endmodule : tone_gen_host
`default_nettype wire

// File: sim/tone_gen_checker.sv
`include "tone_gen_defines.svh"
`default_nettype none
// ==========================================
// Bus handshake checks between the two ends
module tone_gen_checker #(
  parameter int LOAD_CYC = `LOAD_CYC_FAST  // Load length of the device end
) (
  // Clock and reset
  input wire logic       clk_sys_in,
  input wire logic       rst_in,
  // Bus signals
  input wire logic       chip_sel_n,
  input wire logic       write_n,
  input wire logic [7:0] data,
  input wire logic       ready
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Short lower bound; a fast-variant load of 32 cycles is much longer, but a 4-cycle slow-variant load fails it
  sequence s_busy;
    !ready [*8];
  endsequence
  property p_ready_falls; $fell(chip_sel_n) |-> ##[1:4] !ready; endproperty
  a_ready_falls: assert property (p_ready_falls) else $error("ready late");
  property p_load_len; $fell(ready) |-> s_busy; endproperty
  a_load_len: assert property (p_load_len) else $error("load too short");
  // Cycles with ready low in this load; the exact figure catches an off-by-one loader
  logic [6:0] low_cnt_q;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || ready) low_cnt_q <= 7'h00;
    else low_cnt_q <= low_cnt_q + 7'h01;
  end
  property p_load_exact; $rose(ready) |-> low_cnt_q == 7'(LOAD_CYC); endproperty
  a_load_exact: assert property (p_load_exact) else $error("load length wrong");
  property p_ready_rises; $fell(ready) |-> ##[28:38] ready; endproperty
  a_ready_rises: assert property (p_ready_rises) else $error("ready stuck");
  property p_idle_high; chip_sel_n [*4] |-> ready; endproperty
  a_idle_high: assert property (p_idle_high) else $error("ready low unselected");
  property p_data_hold; !ready && !chip_sel_n |=> $stable(data); endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved");
  property p_wait_strobe; !ready |-> !chip_sel_n && !write_n; endproperty
  a_wait_strobe: assert property (p_wait_strobe) else $error("strobe dropped");
  property p_cs_first; $fell(write_n) |-> !chip_sel_n; endproperty
  a_cs_first: assert property (p_cs_first) else $error("strobe before select");
  property p_release; $rose(ready) |-> ##[1:3] chip_sel_n; endproperty
  a_release: assert property (p_release) else $error("select held");
endmodule : tone_gen_checker
`default_nettype wire

// File: sim/test_programmable_tone_generator.sv
`include "tone_gen_defines.svh"
`default_nettype none
// ==========================================
// Host end driving device end, checked against a small model
module test_programmable_tone_generator;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_in;  // 100 MHz
  logic        rst_in;      // Sync, high
  logic        wr_req_in;   // Write pulse
  logic [7:0]  wr_data_in;  // Byte to send
  logic        busy_out;    // Host busy
  logic        done_out;    // Byte accepted
  logic [3:0]  wave_out;    // Square waves
  logic [15:0] level_cut_bits_out;  // Attenuation codes
  logic [15:0] exp_lv;      // Model of the codes
  int          bad_count;   // Mismatches
  int          checked;     // Comparisons
  int          hp;          // Measured half period
  int          n;           // Period value
  int          hi_cnt;      // Noise high cycles
  tone_bus_if tbus ();
  tone_gen_dev tone_gen_dev_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus(tbus),
    .wave_out(wave_out), .level_cut_bits_out(level_cut_bits_out));
  tone_gen_host tone_gen_host_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .wr_req_in(wr_req_in), .wr_data_in(wr_data_in), .busy_out(busy_out),
    .done_out(done_out), .bus(tbus));
  tone_gen_checker tone_gen_checker_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .chip_sel_n(tbus.chip_sel_n), .write_n(tbus.write_n), .data(tbus.data),
    .ready(tbus.ready));
  // ==========================================
  // Clock and watchdog
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // About 22 writes of 40 clocks, six tone waits and one noise window need
  // some 3,000 clocks; 50,000 leaves ample margin for a slow loader
  initial begin
    #500000;
    bad_count++;
    report_and_stop();
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Send one byte; watch the wire while the device holds ready low
  task automatic wr(input logic [7:0] b);
    int i;
    int lowc;
    logic [7:0] seen;
    logic [7:0] lines;
    lowc = 0;
    seen = 8'h00;
    // Line i of the bus carries byte bit 7-i, so line 0 holds the MSB
    for (i = 0; i < 8; i++) lines[i] = b[7 - i];
    @(posedge clk_sys_in);
    wr_req_in  <= 1'b1;
    wr_data_in <= b;
    @(posedge clk_sys_in);
    wr_req_in <= 1'b0;
    for (i = 0; i < 300 && done_out !== 1'b1; i++) begin
      @(posedge clk_sys_in);
      #1;
      if (i == 0) chk({15'h0000, busy_out}, 16'h0001);
      if (tbus.ready === 1'b0) begin
        lowc++;
        seen = tbus.data;
      end
    end
    chk({8'h00, seen}, {8'h00, lines});
    chk(16'(lowc), 16'(`LOAD_CYC_FAST));
    chk({14'h0000, busy_out, done_out}, 16'h0001);
  endtask : wr
  // Half period of one channel, after two toggles so the new value is in use
  task automatic meas(input int ch, output int c);
    int i;
    int k;
    logic w;
    c = 0;
    for (k = 0; k < 3; k++) begin
      w = wave_out[ch];
      c = 0;
      for (i = 0; i < 5000 && wave_out[ch] === w; i++) begin
        @(posedge clk_sys_in);
        #1;
        c++;
      end
    end
  endtask : meas
  // ==========================================
  // Verdict
  task automatic report_and_stop();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================
  // Main sequence
  initial begin
    bad_count = 0;
    checked = 0;
    rst_in = 1'b1;
    wr_req_in = 1'b0;
    wr_data_in = 8'h00;
    exp_lv = 16'hFFFF;
    void'($urandom(18304));
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    #1;
    chk(level_cut_bits_out, exp_lv);
    // Attenuation of all four channels, random codes then the off code
    for (int r = 0; r < 3; r++) begin
      for (int ch = 0; ch < 4; ch++) begin
        logic [3:0] code;
        code = (r == 2) ? 4'hF : 4'($urandom % 15);
        wr({1'b1, 3'(ch * 2 + 1), code});
        exp_lv[ch*4+:4] = code;
        chk(level_cut_bits_out, exp_lv);
      end
    end
    $display("test attenuation done");
    // Tone periods: two-byte load, then a second-format byte alone
    for (int ch = 0; ch < 3; ch++) begin
      n = 4 + $urandom % 12;
      wr({1'b1, 3'(ch * 2), 4'(n)});
      wr(8'h00);
      meas(ch, hp);
      chk(16'(hp), 16'(2 * n));
      n = n + 16;
      wr(8'h01);
      meas(ch, hp);
      chk(16'(hp), 16'(2 * n));
    end
    $display("test tone done");
    // Noise: periodic feedback at the 64-clock rate rotates the seed through
    // bit 0, so a window longer than 16 steps holds 64 high clocks per seed one
    wr({1'b1, `DEST_NOISE_CTL, 4'h0});
    repeat (2) @(posedge clk_sys_in);
    hi_cnt = 0;
    for (int t = 0; t < 1088; t++) begin
      @(posedge clk_sys_in);
      #1;
      if (wave_out[3] === 1'b1) hi_cnt++;
    end
    chk(16'(hi_cnt), 16'(64 * $countones(`LFSR_SEED)));
    $display("test noise done");
    report_and_stop();
  end
endmodule : test_programmable_tone_generator
`default_nettype wire
